// File: dv/pmcc_host_model.sv
`timescale 1ns/1ns
module pmcc_host_model (
    // Clock
    input wire logic core_clk_i,
    // Configuration path
    output logic cfg_wr_o,
    output logic [15:0] cfg_wdata_o,
    output logic gc_enable_o,
    output logic gc_disable_o,
    // Pins
    output logic addr_strap_pin_o,
    output logic scl_o,
    output logic sda_o
);
    logic [1:0] strap_mode;

    initial
    begin
        cfg_wr_o = 1'b0;
        cfg_wdata_o = 16'h0000;
        gc_enable_o = 1'b0;
        gc_disable_o = 1'b0;
        scl_o = 1'b1;
        sda_o = 1'b1;
        strap_mode = pmcc_pkg::STRAP_GND;
    end

    // Strap tied to a bus line follows that line, so its coupling is real
    always_comb
    begin
        case (strap_mode)
            pmcc_pkg::STRAP_VS: addr_strap_pin_o = 1'b1;
            pmcc_pkg::STRAP_SDA: addr_strap_pin_o = sda_o;
            pmcc_pkg::STRAP_SCL: addr_strap_pin_o = scl_o;
            default: addr_strap_pin_o = 1'b0;
        endcase
    end

    // One-cycle strobes; data is scrambled once released so stale values never pass
    task automatic send(input logic [15:0] data, input logic wr, input logic gen,
                        input logic gdis);
        @(posedge core_clk_i);
        #1;
        cfg_wr_o = wr;
        cfg_wdata_o = data;
        gc_enable_o = gen;
        gc_disable_o = gdis;
        @(posedge core_clk_i);
        #1;
        cfg_wr_o = 1'b0;
        cfg_wdata_o = ~data;
        gc_enable_o = 1'b0;
        gc_disable_o = 1'b0;
    endtask

    // Each pulse leaves the line high again, so no second write lands in one time step
    task automatic toggle_scl(input int n);
        repeat (n)
        begin
            repeat (2) @(posedge core_clk_i);
            #1;
            scl_o = 1'b0;
            repeat (2) @(posedge core_clk_i);
            #1;
            scl_o = 1'b1;
        end
    endtask

    task automatic toggle_sda(input int n);
        repeat (n)
        begin
            repeat (2) @(posedge core_clk_i);
            #1;
            sda_o = 1'b0;
            repeat (2) @(posedge core_clk_i);
            #1;
            sda_o = 1'b1;
        end
    endtask
endmodule

// File: dv/tb.sv
`timescale 1ns/1ns
module tb;
    localparam int SETTLE = 10;
    localparam int DET = 8;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cfg_wr, gc_en, gc_dis, strap, scl, sda;
    logic [15:0] cfg_wdata, cfg_rdata_o;
    logic [1:0] addr_sel_o;
    logic addr_valid_o, route_bus_o, route_shunt_o, route_power_o, power_load_side_o;
    logic [2:0] shunt_gain_sel_o, bus_atten_sel_o;
    logic analog_en_o, out_valid_o;
    int bad_count = 0;
    int comparisons = 0;

    always #5 core_clk_i = ~core_clk_i;

    pmcc_host_model i_pmcc_host_model (.core_clk_i(core_clk_i), .cfg_wr_o(cfg_wr),
        .cfg_wdata_o(cfg_wdata), .gc_enable_o(gc_en), .gc_disable_o(gc_dis),
        .addr_strap_pin_o(strap), .scl_o(scl), .sda_o(sda));

    pmcc_core #(.SETTLE_CYC(SETTLE), .DET_CYC(DET)) i_pmcc_core (.core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr), .cfg_wdata_i(cfg_wdata),
        .cfg_rdata_o(cfg_rdata_o), .gc_enable_i(gc_en), .gc_disable_i(gc_dis),
        .addr_strap_pin_i(strap), .scl_i(scl), .sda_i(sda), .addr_sel_o(addr_sel_o),
        .addr_valid_o(addr_valid_o), .route_bus_o(route_bus_o),
        .route_shunt_o(route_shunt_o), .route_power_o(route_power_o),
        .power_load_side_o(power_load_side_o), .shunt_gain_sel_o(shunt_gain_sel_o),
        .bus_atten_sel_o(bus_atten_sel_o), .analog_en_o(analog_en_o),
        .out_valid_o(out_valid_o));

    task automatic give_verdict();
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [2:0] gain_oh(input logic [1:0] c);
        case (c)
            pmcc_pkg::GSV_128: return pmcc_pkg::GSW_128;
            pmcc_pkg::GSV_300: return pmcc_pkg::GSW_300;
            default: return pmcc_pkg::GSW_20;
        endcase
    endfunction

    // Reserved code falls to the strongest attenuation, keeping the mux out of saturation
    function automatic logic [2:0] atten_oh(input logic [1:0] c);
        case (c)
            pmcc_pkg::GBV_2_5: return pmcc_pkg::BSW_2_5;
            pmcc_pkg::GBV_1_5: return pmcc_pkg::BSW_1_5;
            default: return pmcc_pkg::BSW_1_10;
        endcase
    endfunction

    task automatic check_cfg(input logic [15:0] d, input logic en);
        cmp_val(cfg_rdata_o, {9'h000, en, d[5:0]}, "readback");
        cmp_val(16'(route_bus_o), 16'(d[5:4] == 2'h0), "route bus");
        cmp_val(16'(route_shunt_o), 16'(d[5:4] == 2'h1), "route shunt");
        cmp_val(16'(route_power_o), 16'(d[5]), "route power");
        cmp_val(16'(power_load_side_o), 16'(d[5:4] == 2'h3), "load side");
        cmp_val(16'(route_bus_o) + 16'(route_shunt_o) + 16'(route_power_o), 16'h0001,
            "route count");
        cmp_val(16'(shunt_gain_sel_o), 16'(gain_oh(d[3:2])), "gain");
        cmp_val(16'(bus_atten_sel_o), 16'(atten_oh(d[1:0])), "atten");
        cmp_val(16'(analog_en_o), 16'(en), "analog enable");
        if (!en)
            cmp_val(16'(out_valid_o), 16'h0000, "valid while off");
    endtask

    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        rst_n_i = 1'b1;
    endtask

    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        logic [1:0] modes [4];
        logic [15:0] d;
        modes = '{pmcc_pkg::STRAP_GND, pmcc_pkg::STRAP_VS, pmcc_pkg::STRAP_SCL,
            pmcc_pkg::STRAP_SDA};
        void'($urandom(32'hD58CDA88));
        #1;
        foreach (modes[m])
        begin
            i_pmcc_host_model.strap_mode = modes[m];
            do_reset();
            if (m == 0)
            begin
                check_cfg(16'h0061, 1'b1);
                cmp_val(16'(out_valid_o), 16'h0000, "valid at reset");
                cmp_val(16'(addr_valid_o), 16'h0000, "strap early");
            end
            if (modes[m] == pmcc_pkg::STRAP_SCL)
                i_pmcc_host_model.toggle_scl(30);
            else if (modes[m] == pmcc_pkg::STRAP_SDA)
                i_pmcc_host_model.toggle_sda(30);
            else
                repeat (40) @(posedge core_clk_i);
            #2;
            cmp_val(16'(addr_valid_o), 16'h0001, "strap valid");
            cmp_val(16'(addr_sel_o), 16'(modes[m]), "strap code");
        end
        cmp_val(16'(out_valid_o), 16'h0001, "power-on settle");
        i_pmcc_host_model.send(16'h0016, 1'b1, 1'b0, 1'b0);
        check_cfg(16'h0016, 1'b0);
        // Upper bits carry ones that must be dropped
        i_pmcc_host_model.send(16'hFF96, 1'b1, 1'b0, 1'b0);
        check_cfg(16'h0016, 1'b0);
        i_pmcc_host_model.send(16'h0061, 1'b1, 1'b0, 1'b0);
        check_cfg(16'h0061, 1'b1);
        repeat (SETTLE - 1) @(posedge core_clk_i);
        #1;
        cmp_val(16'(out_valid_o), 16'h0000, "valid too early");
        @(posedge core_clk_i);
        #1;
        cmp_val(16'(out_valid_o), 16'h0001, "valid late");
        i_pmcc_host_model.send(16'h0041, 1'b1, 1'b0, 1'b0);
        cmp_val(16'(out_valid_o), 16'h0001, "no restart");
        i_pmcc_host_model.send(16'h0000, 1'b0, 1'b0, 1'b1);
        check_cfg(16'h0001, 1'b0);
        i_pmcc_host_model.send(16'h0000, 1'b0, 1'b1, 1'b0);
        check_cfg(16'h0001, 1'b1);
        i_pmcc_host_model.send(16'h0000, 1'b0, 1'b1, 1'b1);
        check_cfg(16'h0001, 1'b0);
        i_pmcc_host_model.send(16'h0055, 1'b1, 1'b0, 1'b1);
        check_cfg(16'h0055, 1'b0);
        i_pmcc_host_model.send(16'h0023, 1'b1, 1'b1, 1'b0);
        check_cfg(16'h0023, 1'b1);
        // Every field combination, random enable and junk upper bits
        for (int k = 0; k < 64; k++)
        begin
            d = 16'($urandom()) & 16'hFFC0;
            d[5:0] = 6'(k);
            i_pmcc_host_model.send(d, 1'b1, 1'b0, 1'b0);
            check_cfg(d, d[6]);
        end
        give_verdict();
    end
endmodule

// File: rtl/pmcc_core.sv
`timescale 1ns/1ns
module pmcc_core #(
    parameter int SETTLE_CYC = pmcc_pkg::SETTLE_CYC,
    parameter int DET_CYC = pmcc_pkg::DET_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Configuration word from the serial slave
    input wire logic cfg_wr_i,
    input wire logic [pmcc_pkg::CFG_W-1:0] cfg_wdata_i,
    output logic [pmcc_pkg::CFG_W-1:0] cfg_rdata_o,
    // General-call commands, one-cycle pulses
    input wire logic gc_enable_i,
    input wire logic gc_disable_i,
    // Address strap and bus lines as seen at the pins
    input wire logic addr_strap_pin_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic [1:0] addr_sel_o,
    output logic addr_valid_o,
    // Analog output mux controls
    output logic route_bus_o,
    output logic route_shunt_o,
    output logic route_power_o,
    output logic power_load_side_o,
    // Gain switch controls, one-hot
    output logic [2:0] shunt_gain_sel_o,
    output logic [2:0] bus_atten_sel_o,
    // Power state
    output logic analog_en_o,
    output logic out_valid_o
);
    localparam int SETTLE_M1 = SETTLE_CYC - 1;
    localparam logic [pmcc_pkg::SETTLE_CW-1:0] SETTLE_LAST = SETTLE_M1[pmcc_pkg::SETTLE_CW-1:0];

    logic [pmcc_pkg::CFG_W-1:0] cfg_reg;
    logic [pmcc_pkg::CFG_W-1:0] cfg_next;
    logic en_next;
    logic [1:0] out_field;
    logic [1:0] gsv_field;
    logic [1:0] gbv_field;
    pmcc_pkg::pmcc_pwr_type pwr_reg;
    pmcc_pkg::pmcc_pwr_type pwr_next;
    logic [pmcc_pkg::SETTLE_CW-1:0] settle_reg;
    logic [pmcc_pkg::SETTLE_CW-1:0] settle_next;
    logic route_bus_reg;
    logic route_shunt_reg;
    logic route_power_reg;
    logic load_side_reg;
    logic [2:0] gsw_reg;
    logic [2:0] bsw_reg;
    logic analog_en_reg;
    logic out_valid_reg;
    logic [1:0] addr_sel_reg;
    logic addr_valid_reg;

    pmcc_strap_if strap_bus ();

    pmcc_strap_decode #(
        .DET_CYC(DET_CYC)
    ) u_strap (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .addr_strap_pin_i(addr_strap_pin_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .strap(strap_bus.src)
    );

    // Enable source priority: disable command, enable command, then the written bit
    always_comb
    begin
        if (gc_disable_i)
            en_next = 1'b0;
        else if (gc_enable_i)
            en_next = 1'b1;
        else if (cfg_wr_i)
            en_next = cfg_wdata_i[pmcc_pkg::EN_BIT];
        else
            en_next = cfg_reg[pmcc_pkg::EN_BIT];
    end

    // Reserved bits are masked on write so they always read back as zero
    always_comb
    begin
        cfg_next = cfg_reg;
        if (cfg_wr_i)
            cfg_next = cfg_wdata_i & pmcc_pkg::CFG_WMASK;
        cfg_next[pmcc_pkg::EN_BIT] = en_next;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cfg_reg <= pmcc_pkg::CFG_POR;
        else
            cfg_reg <= cfg_next;
    end

    assign out_field = cfg_next[pmcc_pkg::OUT_HI:pmcc_pkg::OUT_LO];
    assign gsv_field = cfg_next[pmcc_pkg::GSV_HI:pmcc_pkg::GSV_LO];
    assign gbv_field = cfg_next[pmcc_pkg::GBV_HI:pmcc_pkg::GBV_LO];

    // Decoding the next value keeps switches in step with the readback word
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            route_bus_reg <= 1'b0;
            route_shunt_reg <= 1'b0;
            route_power_reg <= 1'b1;
            load_side_reg <= 1'b0;
        end
        else
        begin
            route_bus_reg <= (out_field == pmcc_pkg::OUT_BUS);
            route_shunt_reg <= (out_field == pmcc_pkg::OUT_SHUNT);
            route_power_reg <= (out_field == pmcc_pkg::OUT_SUPPLY_PWR) ||
                               (out_field == pmcc_pkg::OUT_LOAD_PWR);
            load_side_reg <= (out_field == pmcc_pkg::OUT_LOAD_PWR);
        end
    end

    // Reserved gain code falls back to the lowest gain so the output cannot overrange
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            gsw_reg <= pmcc_pkg::GSW_20;
        else
            case (gsv_field)
                pmcc_pkg::GSV_20: gsw_reg <= pmcc_pkg::GSW_20;
                pmcc_pkg::GSV_128: gsw_reg <= pmcc_pkg::GSW_128;
                pmcc_pkg::GSV_300: gsw_reg <= pmcc_pkg::GSW_300;
                default: gsw_reg <= pmcc_pkg::GSW_20;
            endcase
    end

    // Reserved attenuation code takes the strongest divider to keep the node below supply
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            bsw_reg <= pmcc_pkg::BSW_1_5;
        else
            case (gbv_field)
                pmcc_pkg::GBV_2_5: bsw_reg <= pmcc_pkg::BSW_2_5;
                pmcc_pkg::GBV_1_5: bsw_reg <= pmcc_pkg::BSW_1_5;
                pmcc_pkg::GBV_1_10: bsw_reg <= pmcc_pkg::BSW_1_10;
                default: bsw_reg <= pmcc_pkg::BSW_1_10;
            endcase
    end

    // Power state; output is flagged valid only after the settling time
    always_comb
    begin
        pwr_next = pwr_reg;
        settle_next = settle_reg;
        case (pwr_reg)
            pmcc_pkg::PMCC_DISABLED:
            begin
                settle_next = '0;
                if (en_next)
                    pwr_next = pmcc_pkg::PMCC_SETTLING;
            end
            pmcc_pkg::PMCC_SETTLING:
            begin
                settle_next = settle_reg + 1'b1;
                if (!en_next)
                    pwr_next = pmcc_pkg::PMCC_DISABLED;
                else if (settle_reg == SETTLE_LAST)
                    pwr_next = pmcc_pkg::PMCC_ACTIVE;
            end
            pmcc_pkg::PMCC_ACTIVE:
            begin
                if (!en_next)
                    pwr_next = pmcc_pkg::PMCC_DISABLED;
            end
            default:
                pwr_next = pmcc_pkg::PMCC_DISABLED;
        endcase
        if (pwr_next != pmcc_pkg::PMCC_SETTLING)
            settle_next = '0;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pwr_reg <= pmcc_pkg::PMCC_SETTLING;
            settle_reg <= '0;
        end
        else
        begin
            pwr_reg <= pwr_next;
            settle_reg <= settle_next;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            analog_en_reg <= 1'b1;
            out_valid_reg <= 1'b0;
        end
        else
        begin
            analog_en_reg <= en_next;
            out_valid_reg <= (pwr_next == pmcc_pkg::PMCC_ACTIVE);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            addr_sel_reg <= pmcc_pkg::STRAP_GND;
            addr_valid_reg <= 1'b0;
        end
        else
        begin
            addr_sel_reg <= strap_bus.code;
            addr_valid_reg <= strap_bus.valid;
        end
    end

    assign cfg_rdata_o = cfg_reg;
    assign route_bus_o = route_bus_reg;
    assign route_shunt_o = route_shunt_reg;
    assign route_power_o = route_power_reg;
    assign power_load_side_o = load_side_reg;
    assign shunt_gain_sel_o = gsw_reg;
    assign bus_atten_sel_o = bsw_reg;
    assign analog_en_o = analog_en_reg;
    assign out_valid_o = out_valid_reg;
    assign addr_sel_o = addr_sel_reg;
    assign addr_valid_o = addr_valid_reg;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_en_rise;
        !analog_en_o ##1 analog_en_o;
    endsequence

    sequence s_plain_write;
        cfg_wr_i && !gc_enable_i && !gc_disable_i;
    endsequence

    a_por_config: assert property ($rose(rst_n_i) |-> cfg_rdata_o == pmcc_pkg::CFG_POR)
        else $error("config not at power-on value");
    a_write_store: assert property (s_plain_write |=>
        cfg_rdata_o == ($past(cfg_wdata_i) & pmcc_pkg::CFG_WMASK))
        else $error("written config not stored");
    a_gc_disable: assert property (gc_disable_i |=> !analog_en_o && !out_valid_o)
        else $error("disable command ignored");
    a_gc_enable: assert property (gc_enable_i && !gc_disable_i |=> analog_en_o)
        else $error("enable command ignored");
    a_write_disable: assert property (s_plain_write and !cfg_wdata_i[pmcc_pkg::EN_BIT]
        |=> !analog_en_o && !cfg_rdata_o[pmcc_pkg::EN_BIT])
        else $error("enable bit write zero ignored");
    a_route_onehot: assert property ($onehot({route_bus_o, route_shunt_o, route_power_o}))
        else $error("output route not exactly one");
    a_route_decode: assert property (
        cfg_rdata_o[pmcc_pkg::OUT_HI:pmcc_pkg::OUT_LO] == pmcc_pkg::OUT_LOAD_PWR
        |-> route_power_o && power_load_side_o)
        else $error("load power mode misdecoded");
    a_shunt_decode: assert property (
        cfg_rdata_o[pmcc_pkg::GSV_HI:pmcc_pkg::GSV_LO] == pmcc_pkg::GSV_128
        |-> shunt_gain_sel_o == pmcc_pkg::GSW_128)
        else $error("shunt gain 128 misdecoded");
    a_gain_safe: assert property (cfg_rdata_o[pmcc_pkg::GSV_HI:pmcc_pkg::GSV_LO] == 2'h3
        |-> shunt_gain_sel_o == pmcc_pkg::GSW_20 && bus_atten_sel_o != 3'h0)
        else $error("reserved gain code not safe");
    a_atten_decode: assert property (
        cfg_rdata_o[pmcc_pkg::GBV_HI:pmcc_pkg::GBV_LO] == pmcc_pkg::GBV_1_10
        |-> bus_atten_sel_o == pmcc_pkg::BSW_1_10)
        else $error("attenuation one tenth misdecoded");
    a_settle_hold: assert property (s_en_rise |-> !out_valid_o [*8])
        else $error("output valid too soon after enable");
    a_valid_needs_en: assert property (out_valid_o |-> analog_en_o)
        else $error("output valid while disabled");
endmodule

// File: rtl/pmcc_pkg.sv
package pmcc_pkg;
    localparam int CFG_W = 16;
    localparam int EN_BIT = 6;
    localparam int OUT_HI = 5;
    localparam int OUT_LO = 4;
    localparam int GSV_HI = 3;
    localparam int GSV_LO = 2;
    localparam int GBV_HI = 1;
    localparam int GBV_LO = 0;
    localparam logic [CFG_W-1:0] CFG_POR = 16'h0061;
    localparam logic [CFG_W-1:0] CFG_WMASK = 16'h007F;

    // Output mode codes
    localparam logic [1:0] OUT_BUS = 2'h0;
    localparam logic [1:0] OUT_SHUNT = 2'h1;
    localparam logic [1:0] OUT_SUPPLY_PWR = 2'h2;
    localparam logic [1:0] OUT_LOAD_PWR = 2'h3;

    // Shunt gain codes and one-hot switch drives
    localparam logic [1:0] GSV_20 = 2'h0;
    localparam logic [1:0] GSV_128 = 2'h1;
    localparam logic [1:0] GSV_300 = 2'h2;
    localparam logic [2:0] GSW_20 = 3'h1;
    localparam logic [2:0] GSW_128 = 3'h2;
    localparam logic [2:0] GSW_300 = 3'h4;

    // Bus attenuation codes and one-hot switch drives
    localparam logic [1:0] GBV_2_5 = 2'h0;
    localparam logic [1:0] GBV_1_5 = 2'h1;
    localparam logic [1:0] GBV_1_10 = 2'h2;
    localparam logic [2:0] BSW_2_5 = 3'h1;
    localparam logic [2:0] BSW_1_5 = 3'h2;
    localparam logic [2:0] BSW_1_10 = 3'h4;

    // Strap decode results
    localparam logic [1:0] STRAP_GND = 2'h0;
    localparam logic [1:0] STRAP_VS = 2'h1;
    localparam logic [1:0] STRAP_SDA = 2'h2;
    localparam logic [1:0] STRAP_SCL = 2'h3;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int SETTLE_US = 40;
    localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int SETTLE_CW = 12;
    localparam int SYNC_FILL = 3;
    localparam int DET_CYC = 32;
    localparam int DET_CW = 6;

    typedef enum logic [1:0] {PMCC_DISABLED, PMCC_SETTLING, PMCC_ACTIVE} pmcc_pwr_type;
endpackage

// File: rtl/pmcc_strap_decode.sv
`timescale 1ns/1ns
module pmcc_strap_decode #(
    parameter int DET_CYC = pmcc_pkg::DET_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Raw pins
    input wire logic addr_strap_pin_i,
    input wire logic scl_i,
    input wire logic sda_i,
    // Result
    pmcc_strap_if.src strap
);
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] sync3_reg;
    logic [2:0] filt_reg;
    logic [pmcc_pkg::DET_CW-1:0] win_reg;
    logic seen_hi_reg;
    logic seen_lo_reg;
    logic neq_scl_reg;
    logic neq_sda_reg;
    logic [1:0] code_reg;
    logic valid_reg;
    logic sample;

    localparam int CW = pmcc_pkg::DET_CW;
    localparam int FILL_CYC = pmcc_pkg::SYNC_FILL + 1;
    localparam logic [CW-1:0] DET_CW_MAX = DET_CYC[CW-1:0];
    localparam logic [CW-1:0] FILL = FILL_CYC[CW-1:0];

    // Bit 2 strap, bit 1 SCL, bit 0 SDA
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            sync3_reg <= 3'h0;
        end
        else
        begin
            sync1_reg <= {addr_strap_pin_i, scl_i, sda_i};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // A level is taken only once the last two stages agree
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            filt_reg <= 3'h0;
        else
            filt_reg <= (sync3_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            win_reg <= '0;
        else if (win_reg != DET_CW_MAX)
            win_reg <= win_reg + 1'b1;
    end

    // Filter output is meaningless until the pipeline has filled after reset
    assign sample = (win_reg >= FILL);

    // Observation keeps running, so a strap tied to an idle bus line is refined later
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            seen_hi_reg <= 1'b0;
            seen_lo_reg <= 1'b0;
            neq_scl_reg <= 1'b0;
            neq_sda_reg <= 1'b0;
        end
        else if (sample)
        begin
            seen_hi_reg <= seen_hi_reg | filt_reg[2];
            seen_lo_reg <= seen_lo_reg | ~filt_reg[2];
            neq_scl_reg <= neq_scl_reg | (filt_reg[2] ^ filt_reg[1]);
            neq_sda_reg <= neq_sda_reg | (filt_reg[2] ^ filt_reg[0]);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            code_reg <= pmcc_pkg::STRAP_GND;
            valid_reg <= 1'b0;
        end
        else
        begin
            valid_reg <= valid_reg | (win_reg == DET_CW_MAX);
            if (seen_hi_reg && seen_lo_reg)
            begin
                // A strap that follows neither line exactly keeps its last code
                if (!neq_scl_reg)
                    code_reg <= pmcc_pkg::STRAP_SCL;
                else if (!neq_sda_reg)
                    code_reg <= pmcc_pkg::STRAP_SDA;
            end
            else if (seen_hi_reg)
                code_reg <= pmcc_pkg::STRAP_VS;
            else
                code_reg <= pmcc_pkg::STRAP_GND;
        end
    end

    assign strap.code = code_reg;
    assign strap.valid = valid_reg;

    a_strap_valid_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $past(valid_reg) |-> valid_reg) else $error("strap valid dropped");
endmodule

// File: rtl/pmcc_strap_if.sv
`timescale 1ns/1ns
interface pmcc_strap_if;
    logic [1:0] code;
    logic valid;
    modport src (output code, output valid);
    modport snk (input code, input valid);
endinterface
